// *** design/pin_mux_pkg.sv ***
// shared constants and carrier types for the port pin function mux
package pin_mux_pkg;

  // ----------------------------------------------------------------
  // port widths
  // ----------------------------------------------------------------
  localparam int ANALOG_W = 4;
  localparam int TIMER_W  = 2;
  localparam int SIX_W    = 6;
  localparam int OSC_W    = 3;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int TMR_CLK_CAP_BIT = 0;
  localparam int TMR_CAP_OUT_BIT = 1;
  localparam int AUX_OUT_BIT     = 2;
  localparam int IRQ_D_BIT       = 1;
  localparam int TXD_BIT         = 3;
  localparam int RXD_BIT         = 4;
  localparam int OSC_IN_BIT      = 0;
  localparam int OSC_OUT_BIT     = 1;
  localparam int OSC_PULL_BIT    = 2;
  localparam int IRQ_N           = 4;

  // ----------------------------------------------------------------
  // reset values: direction 1 = input
  // ----------------------------------------------------------------
  localparam logic [ANALOG_W-1:0] ANALOG_DIR_RST = 4'hf;
  localparam logic [TIMER_W-1:0]  TIMER_DIR_RST  = 2'h3;
  localparam logic [SIX_W-1:0]    SIX_DIR_RST    = 6'h3f;
  localparam logic [OSC_W-1:0]    OSC_DIR_RST    = 3'h7;
  localparam logic [7:0]          ZERO_RST       = 8'h00;

  // ----------------------------------------------------------------
  // edge select encoding
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    EDGE_NONE    = 2'h0,
    EDGE_RISE    = 2'h1,
    EDGE_FALL    = 2'h2,
    EDGE_BOTH    = 2'h3
  } edge_sel_t;

  typedef struct packed {
    logic [SIX_W-1:0]    six;
    logic [OSC_W-1:0]    osc;
    logic [TIMER_W-1:0]  tmr;
    logic [ANALOG_W-1:0] ana;
  } port_bits_t;

  typedef struct packed {
    logic tmr_wide_out;
    logic aux_out;
    logic txd;
  } periph_out_t;

endpackage

// *** design/edge_detect.sv ***
// one external interrupt edge detector
`timescale 1ns/1ps
`default_nettype none
module edge_detect (
  input  wire logic                    ref_clk,
  input  wire logic                    rst,
  input  wire logic                    pin_in,
  input  wire pin_mux_pkg::edge_sel_t  sel,
  output logic                         irq_pulse
);
  logic prev_reg;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      // start from the pin level, no false edge after reset
      prev_reg  <= pin_in;
      irq_pulse <= 1'b0;
    end else begin
      prev_reg  <= pin_in;
      // rising, falling or both
      irq_pulse <= (sel[0] & pin_in & ~prev_reg) | (sel[1] & ~pin_in & prev_reg);
    end
  end

  rise_edge_a: assert property (@(posedge ref_clk) disable iff (rst)
    (sel == pin_mux_pkg::EDGE_RISE && $rose(pin_in)) |=> irq_pulse)
    else $error("rising edge missed");
  fall_ignore_a: assert property (@(posedge ref_clk) disable iff (rst)
    (sel == pin_mux_pkg::EDGE_RISE && $fell(pin_in)) |=> !irq_pulse)
    else $error("falling edge taken in rise mode");
endmodule // edge_detect
`default_nettype wire

// *** design/port_bit_cell.sv ***
// one bidirectional port bit with latch, direction and pull-up
`timescale 1ns/1ps
`default_nettype none
module port_bit_cell (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic dir_in,
  input  wire logic latch_val,
  input  wire logic alt_en,
  input  wire logic alt_val,
  input  wire logic pull_en,
  input  wire logic pad_in,
  output logic      pad_out,
  output logic      pad_oe_n,
  output logic      pad_pull,
  output logic      rd_val
);
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pad_out  <= 1'b0;
      pad_oe_n <= 1'b1;
      pad_pull <= 1'b0;
      rd_val   <= 1'b0;
    end else begin
      pad_out  <= alt_en ? alt_val : latch_val;
      pad_oe_n <= dir_in;
      pad_pull <= pull_en & dir_in;
      rd_val   <= dir_in ? pad_in : latch_val;
    end
  end
endmodule // port_bit_cell
`default_nettype wire

// *** design/port_pin_function_mux.sv ***
// port registers for all pins and alternate function routing for the shared pins
`timescale 1ns/1ps
`default_nettype none
module port_pin_function_mux (
  input  wire logic                       ref_clk,
  input  wire logic                       rst,
  // software side
  input  wire logic                       wr_en,
  input  wire pin_mux_pkg::port_bits_t    wr_latch,
  input  wire pin_mux_pkg::port_bits_t    wr_dir,
  input  wire pin_mux_pkg::port_bits_t    wr_pull,
  input  wire logic [3:0]                 wr_analog_mode,
  input  wire logic [2:0]                 wr_alt_en,
  input  wire logic                       wr_osc_mode,
  input  wire logic                       wr_output_only,
  input  wire logic [7:0]                 wr_edge_sel,
  output pin_mux_pkg::port_bits_t         port_read,
  output logic                            reset_shared_input_bit,
  output logic [3:0]                      analog_port_direction_reg,
  // peripheral side
  input  wire pin_mux_pkg::periph_out_t   periph_out,
  output logic [3:0]                      analog_channel_inputs,
  output logic [3:0]                      ext_irq_pulse,
  output logic                            timer_count_clk,
  output logic                            capture_trig_both,
  output logic                            capture_trig_first,
  output logic                            serial_receive_pin,
  output logic                            osc_clk_out,
  output logic                            osc_feedback,
  // pin side
  input  wire pin_mux_pkg::port_bits_t    pad_in,
  input  wire logic                       reset_pin_n,
  output pin_mux_pkg::port_bits_t         pad_out,
  output pin_mux_pkg::port_bits_t         pad_oe_n,
  output pin_mux_pkg::port_bits_t         pad_pull,
  output logic                            output_only_bit
);
  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  pin_mux_pkg::port_bits_t latch_reg;
  pin_mux_pkg::port_bits_t dir_reg;
  pin_mux_pkg::port_bits_t pull_reg;
  logic [3:0]              analog_mode_reg;
  logic [2:0]              alt_en_reg;
  logic                    osc_mode_reg;
  logic                    timer_clk_sel_reg;
  logic [7:0]              edge_sel_reg;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      latch_reg <= '0;
      dir_reg   <= {pin_mux_pkg::SIX_DIR_RST, pin_mux_pkg::OSC_DIR_RST,
                    pin_mux_pkg::TIMER_DIR_RST, pin_mux_pkg::ANALOG_DIR_RST};
      pull_reg  <= '0;
    end else if (wr_en) begin
      latch_reg <= wr_latch;
      dir_reg   <= wr_dir;
      pull_reg  <= wr_pull;
      pull_reg.osc[pin_mux_pkg::OSC_PULL_BIT-1:0] <= '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      analog_mode_reg   <= '0;
      alt_en_reg        <= '0;
      osc_mode_reg      <= 1'b0;
      timer_clk_sel_reg <= 1'b0;
      edge_sel_reg      <= pin_mux_pkg::ZERO_RST;
      output_only_bit   <= 1'b0;
    end else if (wr_en) begin
      analog_mode_reg   <= wr_analog_mode;
      alt_en_reg        <= wr_alt_en;
      osc_mode_reg      <= wr_osc_mode;
      timer_clk_sel_reg <= wr_edge_sel[0];
      edge_sel_reg      <= wr_edge_sel;
      output_only_bit   <= wr_output_only;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      analog_port_direction_reg <= pin_mux_pkg::ANALOG_DIR_RST;
    end else begin
      analog_port_direction_reg <= dir_reg.ana;
    end
  end

  // ----------------------------------------------------------------
  // pin cells
  // ----------------------------------------------------------------
  localparam int NBITS = $bits(pin_mux_pkg::port_bits_t);
  logic [NBITS-1:0] alt_en_vec;
  logic [NBITS-1:0] alt_val_vec;
  logic [NBITS-1:0] dir_eff;
  pin_mux_pkg::port_bits_t rd_vec;

  always_comb begin
    alt_en_vec  = '0;
    alt_val_vec = '0;
    dir_eff     = dir_reg;
    // analog channels force the pin to input
    dir_eff[pin_mux_pkg::ANALOG_W-1:0] = dir_reg.ana | analog_mode_reg;
    // oscillator pins taken from port use
    if (osc_mode_reg) begin
      dir_eff[pin_mux_pkg::ANALOG_W+pin_mux_pkg::TIMER_W+pin_mux_pkg::OSC_OUT_BIT] = 1'b1;
      dir_eff[pin_mux_pkg::ANALOG_W+pin_mux_pkg::TIMER_W+pin_mux_pkg::OSC_IN_BIT]  = 1'b1;
    end
    alt_en_vec[pin_mux_pkg::ANALOG_W+pin_mux_pkg::TMR_CAP_OUT_BIT]  = alt_en_reg[0];
    alt_val_vec[pin_mux_pkg::ANALOG_W+pin_mux_pkg::TMR_CAP_OUT_BIT] = periph_out.tmr_wide_out;
    alt_en_vec[NBITS-pin_mux_pkg::SIX_W+pin_mux_pkg::AUX_OUT_BIT]   = alt_en_reg[1];
    alt_val_vec[NBITS-pin_mux_pkg::SIX_W+pin_mux_pkg::AUX_OUT_BIT]  = periph_out.aux_out;
    alt_en_vec[NBITS-pin_mux_pkg::SIX_W+pin_mux_pkg::TXD_BIT]       = alt_en_reg[2];
    alt_val_vec[NBITS-pin_mux_pkg::SIX_W+pin_mux_pkg::TXD_BIT]      = periph_out.txd;
  end

  genvar g;
  generate
    for (g = 0; g < NBITS; g++) begin : g_cell
      port_bit_cell u_cell (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .dir_in    (dir_eff[g]),
        .latch_val (latch_reg[g]),
        .alt_en    (alt_en_vec[g]),
        .alt_val   (alt_val_vec[g]),
        .pull_en   (pull_reg[g]),
        .pad_in    (pad_in[g]),
        .pad_out   (pad_out[g]),
        .pad_oe_n  (pad_oe_n[g]),
        .pad_pull  (pad_pull[g]),
        .rd_val    (rd_vec[g])
      );
    end
  endgenerate

  assign port_read = rd_vec;

  // ----------------------------------------------------------------
  // inward alternate functions
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      analog_channel_inputs  <= '0;
      timer_count_clk        <= 1'b0;
      capture_trig_both      <= 1'b0;
      capture_trig_first     <= 1'b0;
      serial_receive_pin     <= 1'b1;
      osc_clk_out            <= 1'b0;
      osc_feedback           <= 1'b0;
      reset_shared_input_bit <= 1'b1;
    end else begin
      analog_channel_inputs  <= pad_in.ana & analog_mode_reg;
      timer_count_clk        <= timer_clk_sel_reg & pad_in.tmr[pin_mux_pkg::TMR_CLK_CAP_BIT];
      capture_trig_both      <= ~timer_clk_sel_reg & pad_in.tmr[pin_mux_pkg::TMR_CLK_CAP_BIT];
      capture_trig_first     <= pad_in.tmr[pin_mux_pkg::TMR_CAP_OUT_BIT];
      serial_receive_pin     <= pad_in.six[pin_mux_pkg::RXD_BIT];
      osc_clk_out            <= osc_mode_reg & pad_in.osc[pin_mux_pkg::OSC_IN_BIT];
      osc_feedback           <= osc_mode_reg & ~pad_in.osc[pin_mux_pkg::OSC_IN_BIT];
      reset_shared_input_bit <= reset_pin_n;
    end
  end

  // ----------------------------------------------------------------
  // external interrupt edge detection
  // ----------------------------------------------------------------
  logic [pin_mux_pkg::IRQ_N-1:0] irq_src;
  assign irq_src = {pad_in.six[pin_mux_pkg::IRQ_D_BIT], pad_in.tmr[pin_mux_pkg::TMR_CAP_OUT_BIT],
                    pad_in.six[pin_mux_pkg::TXD_BIT], pad_in.tmr[pin_mux_pkg::TMR_CLK_CAP_BIT]};

  generate
    for (g = 0; g < pin_mux_pkg::IRQ_N; g++) begin : g_irq
      edge_detect u_edge (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .pin_in    (irq_src[g]),
        .sel       (pin_mux_pkg::edge_sel_t'(edge_sel_reg[2*g+:2])),
        .irq_pulse (ext_irq_pulse[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  reset_input_a: assert property (@(posedge ref_clk) $past(rst) |-> pad_oe_n == '1)
    else $error("pin driven after reset");
  analog_in_a: assert property (@(posedge ref_clk) disable iff (rst)
    analog_mode_reg[0] |=> pad_oe_n[0])
    else $error("analog pin driven");
  pull_third_a: assert property (@(posedge ref_clk) disable iff (rst)
    !pad_pull.osc[pin_mux_pkg::OSC_IN_BIT] && !pad_pull.osc[pin_mux_pkg::OSC_OUT_BIT])
    else $error("pull-up on oscillator pin");
  txd_drive_a: assert property (@(posedge ref_clk) disable iff (rst)
    alt_en_reg[2] |=> pad_out[NBITS-pin_mux_pkg::SIX_W+pin_mux_pkg::TXD_BIT] == $past(periph_out.txd))
    else $error("transmit not on pin");
  rxd_pass_a: assert property (@(posedge ref_clk) disable iff (rst)
    1'b1 |=> serial_receive_pin == $past(pad_in.six[pin_mux_pkg::RXD_BIT]))
    else $error("receive data lost");
  cap_first_a: assert property (@(posedge ref_clk) disable iff (rst)
    1'b1 |=> capture_trig_first == $past(pad_in.tmr[pin_mux_pkg::TMR_CAP_OUT_BIT]))
    else $error("capture trigger lost");
  clk_excl_a: assert property (@(posedge ref_clk) disable iff (rst)
    !(timer_count_clk && capture_trig_both))
    else $error("count clock and capture both active");
  dir_out_a: assert property (@(posedge ref_clk) disable iff (rst)
    (wr_en && !wr_dir.six[0]) |=> ##1 !pad_oe_n[NBITS-pin_mux_pkg::SIX_W])
    else $error("six-bit port not driven");
  reset_pin_a: assert property (@(posedge ref_clk) disable iff (rst)
    !reset_pin_n |=> !reset_shared_input_bit)
    else $error("reset pin level lost");

  cov_txd_c:  cover property (@(posedge ref_clk) alt_en_reg[2] && !pad_oe_n[NBITS-3]);
  cov_irq_c:  cover property (@(posedge ref_clk) ext_irq_pulse[0]);
  cov_ana_c:  cover property (@(posedge ref_clk) analog_mode_reg == 4'hf);
  cov_osc_c:  cover property (@(posedge ref_clk) osc_mode_reg && osc_clk_out);
endmodule // port_pin_function_mux
`default_nettype wire

// *** dv/board_model.sv ***
// board side of the pins: pad resolution, pull-ups and the reset line
`timescale 1ns/1ps
`default_nettype none
module board_model (
  input  wire pin_mux_pkg::port_bits_t pad_out,
  input  wire pin_mux_pkg::port_bits_t pad_oe_n,
  input  wire pin_mux_pkg::port_bits_t pad_pull,
  input  wire pin_mux_pkg::port_bits_t ext_val,
  input  wire logic                    ext_rst_n,
  output pin_mux_pkg::port_bits_t      pad_in,
  output logic                         reset_pin_n
);
  // ----------------------------------------------------------------
  // pin level: device driver, else pull-up, else board signal
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < 15; i++) begin
      if (!pad_oe_n[i]) begin
        pad_in[i] = pad_out[i];
      end else if (pad_pull[i]) begin
        pad_in[i] = 1'b1;
      end else begin
        pad_in[i] = ext_val[i];
      end
    end
  end

  // reset line low means reset, high idle
  assign reset_pin_n = ext_rst_n;
endmodule // board_model
`default_nettype wire

// *** dv/testbench.sv ***
// self-checking bench for the port pin function mux
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin err_count++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module testbench;
  logic                     ref_clk, rst, wr_en, wr_osc_mode, wr_output_only, ext_rst_n;
  pin_mux_pkg::port_bits_t  wr_latch, wr_dir, wr_pull, ext_val, port_read;
  pin_mux_pkg::port_bits_t  pad_in, pad_out, pad_oe_n, pad_pull;
  logic [3:0]               wr_analog_mode, analog_port_direction_reg, analog_channel_inputs, ext_irq_pulse;
  logic [2:0]               wr_alt_en;
  logic [7:0]               wr_edge_sel;
  pin_mux_pkg::periph_out_t periph_out;
  logic                     reset_shared_input_bit, reset_pin_n, timer_count_clk, capture_trig_both;
  logic                     capture_trig_first, serial_receive_pin, osc_clk_out, osc_feedback, output_only_bit;
  int                       err_count, check_count, n;
  int                       src [4] = '{4, 12, 5, 10};

  port_pin_function_mux dut_u (.ref_clk(ref_clk), .rst(rst), .wr_en(wr_en), .wr_latch(wr_latch),
    .wr_dir(wr_dir), .wr_pull(wr_pull), .wr_analog_mode(wr_analog_mode), .wr_alt_en(wr_alt_en),
    .wr_osc_mode(wr_osc_mode), .wr_output_only(wr_output_only), .wr_edge_sel(wr_edge_sel),
    .port_read(port_read), .reset_shared_input_bit(reset_shared_input_bit),
    .analog_port_direction_reg(analog_port_direction_reg), .periph_out(periph_out),
    .analog_channel_inputs(analog_channel_inputs), .ext_irq_pulse(ext_irq_pulse),
    .timer_count_clk(timer_count_clk), .capture_trig_both(capture_trig_both),
    .capture_trig_first(capture_trig_first), .serial_receive_pin(serial_receive_pin),
    .osc_clk_out(osc_clk_out), .osc_feedback(osc_feedback), .pad_in(pad_in), .reset_pin_n(reset_pin_n),
    .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_pull(pad_pull), .output_only_bit(output_only_bit));

  board_model board_u (.pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_pull(pad_pull), .ext_val(ext_val),
    .ext_rst_n(ext_rst_n), .pad_in(pad_in), .reset_pin_n(reset_pin_n));

  // ----------------------------------------------------------------
  // clock, closing and watchdog
  // ----------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge ref_clk);
    err_count++;
    end_sim();
  end

  // ----------------------------------------------------------------
  // stimulus and reference model
  // ----------------------------------------------------------------
  task automatic rand_cfg();
    wr_latch       = 15'($urandom);
    wr_dir         = 15'($urandom);
    wr_pull        = 15'($urandom);
    wr_analog_mode = 4'($urandom);
    wr_alt_en      = 3'($urandom);
    wr_osc_mode    = 1'($urandom);
    wr_output_only = 1'($urandom);
    wr_edge_sel    = 8'($urandom);
    periph_out     = 3'($urandom);
    ext_val        = 15'($urandom);
    ext_rst_n      = 1'($urandom);
  endtask

  // second write on the next edge when twice is set
  task automatic write_cfg(input bit twice);
    @(negedge ref_clk);
    wr_en = 1'b1;
    if (twice) begin
      @(negedge ref_clk);
      rand_cfg();
    end
    @(negedge ref_clk);
    wr_en = 1'b0;
    repeat (3) @(negedge ref_clk);
  endtask

  task automatic check_state();
    logic [14:0] inp, ep, pv, xp;
    inp = wr_dir | {6'h00, 1'b0, wr_osc_mode, wr_osc_mode, 2'h0, wr_analog_mode};
    ep = wr_pull & inp & 15'h7f3f;
    pv = wr_latch;
    if (wr_alt_en[0]) pv[5] = periph_out.tmr_wide_out;
    if (wr_alt_en[1]) pv[11] = periph_out.aux_out;
    if (wr_alt_en[2]) pv[12] = periph_out.txd;
    xp = (~inp & pv) | (inp & ep) | (inp & ~ep & ext_val);
    `CHK("pad_oe_n", inp, pad_oe_n)
    `CHK("pad_pull", ep, pad_pull)
    `CHK("pad_out", pv & ~inp, pad_out & ~inp)
    `CHK("port_read", (inp & xp) | (~inp & wr_latch), port_read)
    `CHK("ana_dir", wr_dir[3:0], analog_port_direction_reg)
    `CHK("ana_ch", xp[3:0] & wr_analog_mode, analog_channel_inputs)
    `CHK("cap_first", xp[5], capture_trig_first)
    `CHK("rx", xp[13], serial_receive_pin)
    `CHK("rst_bit", ext_rst_n, reset_shared_input_bit)
    `CHK("out_only", wr_output_only, output_only_bit)
    `CHK("cnt_clk", xp[4] & wr_edge_sel[0], timer_count_clk)
    `CHK("cap_both", xp[4] & ~wr_edge_sel[0], capture_trig_both)
    `CHK("osc_clk", xp[6] & wr_osc_mode, osc_clk_out)
    `CHK("osc_fb", ~xp[6] & wr_osc_mode, osc_feedback)
  endtask

  initial begin
    rst = 1'b1;
    wr_en = 1'b0;
    wr_latch = '0; wr_dir = '1; wr_pull = '0; wr_analog_mode = '0; wr_alt_en = '0;
    wr_osc_mode = 1'b0; wr_output_only = 1'b0; wr_edge_sel = '0;
    periph_out = '0; ext_val = '0; ext_rst_n = 1'b1;
    err_count = 0;
    check_count = 0;
    repeat (8) @(negedge ref_clk);
    rst = 1'b0;
    `CHK("rst_oe_n", 15'h7fff, pad_oe_n)
    `CHK("rst_pull", 15'h0000, pad_pull)
    `CHK("rst_irq", 4'h0, ext_irq_pulse)
    `CHK("rst_bit", 1'b1, reset_shared_input_bit)
    void'($urandom(8));
    for (int k = 0; k < 24; k++) begin
      rand_cfg();
      write_cfg(k[0]);
      check_state();
    end
    // reset in mid-run returns every configured pin to input
    @(negedge ref_clk);
    rst = 1'b1;
    repeat (2) @(negedge ref_clk);
    rst = 1'b0;
    `CHK("mid_oe_n", 15'h7fff, pad_oe_n)
    `CHK("mid_pull", 15'h0000, pad_pull)
    `CHK("mid_out", 15'h0000, pad_out)
    `CHK("mid_rx", 1'b1, serial_receive_pin)
    `CHK("mid_ana_dir", 4'hf, analog_port_direction_reg)
    wr_dir = '1; wr_pull = '0; wr_alt_en = '0; wr_analog_mode = '0; wr_osc_mode = 1'b0;
    for (int i = 0; i < 4; i++) begin
      for (int s = 0; s < 4; s++) begin
        ext_val = '0;
        wr_edge_sel = 8'(s << (2 * i));
        write_cfg(1'b0);
        for (int e = 0; e < 2; e++) begin
          ext_val[src[i]] = (e == 0);
          n = 0;
          repeat (6) begin
            @(negedge ref_clk);
            n += int'(ext_irq_pulse[i] === 1'b1);
          end
          `CHK("irq_count", (s >> e) & 1, n)
        end
      end
    end
    end_sim();
  end
endmodule // testbench
`default_nettype wire
